// ===== dbg_ack_defs.svh
`ifndef DBG_ACK_DEFS_SVH
`define DBG_ACK_DEFS_SVH

// Acknowledge pulse length in target clock cycles.
`define ACK_PULSE_CYCLES 16
`define ACK_CNT_W 5

`endif

// ===== dbg_ack_pkg.sv
package dbg_ack_pkg;

   typedef enum logic [3:0]
   {
      CMD_NONE = 4'h0,
      CMD_ACK_ENABLE = 4'h1,
      CMD_ACK_DISABLE = 4'h2,
      CMD_READ = 4'h3,
      CMD_WRITE = 4'h4,
      CMD_HALT = 4'h5,
      CMD_RESUME = 4'h6,
      CMD_RESUME_UNTIL = 4'h7,
      CMD_STEP = 4'h8,
      CMD_CPU = 4'h9,
      CMD_SYNC = 4'hA
   } cmd_e;

   typedef enum logic [2:0]
   {
      W_IDLE = 3'b000,
      W_BUS = 3'b001,
      W_ENTER = 3'b010,
      W_EXIT = 3'b011,
      W_STEP = 3'b100,
      W_CPU = 3'b101
   } wait_e;

   // One decoded command from the serial shifter, with its data phase done.
   typedef struct packed
   {
      logic valid;
      cmd_e cmd;
   } cmd_s;

   // Processor and internal bus status that closes a pending acknowledge.
   typedef struct packed
   {
      logic bus_done;
      logic cpu_done;
      logic enter_halt_instruction;
      logic exit_halt_instruction;
   } core_evt_s;

endpackage : dbg_ack_pkg

// ===== ack_pulse_gen.sv
`timescale 1ns/1ps
`include "dbg_ack_defs.svh"

module ack_pulse_gen
   import dbg_ack_pkg::*;
#(
   parameter int PULSE_CYCLES = `ACK_PULSE_CYCLES
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic fire,
   input wire logic host_driving,
   output logic pin_out,
   output logic pin_oe,
   output logic busy
);

   logic [`ACK_CNT_W-1:0] cnt_reg;
   logic [`ACK_CNT_W-1:0] cnt_next;
   logic pend_reg;
   logic pend_next;
   logic oe_reg;
   logic oe_next;

   // A request waits until the host releases the pin, then drives it low.
   always_comb
   begin
      cnt_next = cnt_reg;
      pend_next = pend_reg | fire;
      oe_next = oe_reg;
      if (oe_reg)
      begin
         if (cnt_reg == `ACK_CNT_W'(1))
         begin
            oe_next = 1'b0;
         end
         cnt_next = cnt_reg - `ACK_CNT_W'(1);
      end
      else if (pend_next && !host_driving)
      begin
         oe_next = 1'b1;
         pend_next = 1'b0;
         cnt_next = `ACK_CNT_W'(PULSE_CYCLES);
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt_reg <= '0;
         pend_reg <= 1'b0;
         oe_reg <= 1'b0;
      end
      else
      begin
         cnt_reg <= cnt_next;
         pend_reg <= pend_next;
         oe_reg <= oe_next;
      end
   end

   assign pin_out = 1'b0;
   assign pin_oe = oe_reg;
   assign busy = oe_reg | pend_reg;

endmodule : ack_pulse_gen

// ===== debug_port_ack_handshake.sv
// Function
// - Enable command turns handshake on; disable command turns it off.
// - With handshake on, acknowledge after the processor executes a processor command.
// - The enable command is itself acknowledged on completion.
// - Every reset leaves the handshake off.
// - Read acknowledge follows bus cycle completion with data ready to shift.
// - Write acknowledge follows serial data receipt and bus cycle completion.
// - Halt acknowledges when the processor enters background mode.
// - Resume acknowledges when the processor leaves background mode.
// - Resume-until-halt acknowledges on re-entry to background mode, any cause.
// - Single step acknowledges on return to background after one instruction.
// - Timing-probe command cancels a pending run-control acknowledge.
`timescale 1ns/1ps
`include "dbg_ack_defs.svh"

module debug_port_ack_handshake
   import dbg_ack_pkg::*;
#(
   parameter int PULSE_CYCLES = `ACK_PULSE_CYCLES
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire cmd_s cmd_in,
   input wire core_evt_s core_evt,
   input wire logic host_driving,
   output logic debug_serial_pin_out,
   output logic debug_serial_pin_oe,
   output logic ack_enabled,
   output logic ack_waiting
);

   logic en_reg;
   logic en_next;
   wait_e wait_reg;
   wait_e wait_next;
   logic fire_reg;
   logic fire_next;
   logic stay_reg;
   logic stay_next;

   // Only run-control waits may be dropped by the timing probe.
   function automatic logic is_run_ctrl(input wait_e w);
      is_run_ctrl = (w == W_ENTER) || (w == W_EXIT) || (w == W_STEP);
   endfunction : is_run_ctrl

   function automatic logic cmd_is(input cmd_s c, input cmd_e k);
      cmd_is = c.valid && (c.cmd == k);
   endfunction : cmd_is

   // The handshake flag is its own group, so that only the two handshake
   // commands and reset can ever change it.
   always_comb
   begin
      en_next = en_reg;
      if (cmd_is(cmd_in, CMD_ACK_ENABLE))
      begin
         en_next = 1'b1;
      end
      else if (cmd_is(cmd_in, CMD_ACK_DISABLE))
      begin
         en_next = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         en_reg <= 1'b0;
      end
      else
      begin
         en_reg <= en_next;
      end
   end

   // A command other than the enable command that needs an acknowledge parks here until the core reports
   // the event that completes it; a later read, write, processor or run-control command replaces the wait.
   always_comb
   begin
      wait_next = wait_reg;
      fire_next = 1'b0;
      stay_next = stay_reg;
      case (wait_reg)
         W_BUS:
         begin
            if (core_evt.bus_done)
            begin
               fire_next = 1'b1;
               wait_next = W_IDLE;
            end
         end
         W_CPU:
         begin
            if (core_evt.cpu_done)
            begin
               fire_next = 1'b1;
               wait_next = W_IDLE;
            end
         end
         W_ENTER, W_STEP:
         begin
            if (core_evt.enter_halt_instruction)
            begin
               fire_next = 1'b1;
               wait_next = W_IDLE;
            end
         end
         W_EXIT:
         begin
            if (core_evt.exit_halt_instruction)
            begin
               fire_next = 1'b1;
               wait_next = W_IDLE;
            end
         end
         default:
         begin
            wait_next = W_IDLE;
         end
      endcase
      if (cmd_in.valid)
      begin
         case (cmd_in.cmd)
            CMD_ACK_ENABLE:
            begin
               fire_next = 1'b1;
            end
            CMD_ACK_DISABLE:
            begin
               wait_next = W_IDLE;
            end
            CMD_SYNC:
            begin
               // A completion in this same cycle has already happened, so its
               // acknowledge still goes out; only the wait is dropped.
               if (is_run_ctrl(wait_reg))
               begin
                  wait_next = W_IDLE;
               end
            end
            CMD_READ, CMD_WRITE:
            begin
               if (en_reg)
               begin
                  wait_next = W_BUS;
               end
            end
            CMD_CPU:
            begin
               if (en_reg)
               begin
                  wait_next = W_CPU;
               end
            end
            CMD_HALT, CMD_RESUME_UNTIL:
            begin
               if (en_reg)
               begin
                  wait_next = W_ENTER;
               end
            end
            CMD_RESUME:
            begin
               if (en_reg)
               begin
                  wait_next = W_EXIT;
               end
            end
            CMD_STEP:
            begin
               if (en_reg)
               begin
                  wait_next = W_STEP;
               end
            end
            default:
            begin
               stay_next = stay_reg;
            end
         endcase
      end
      stay_next = (wait_next != W_IDLE);
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wait_reg <= W_IDLE;
         fire_reg <= 1'b0;
         stay_reg <= 1'b0;
      end
      else
      begin
         wait_reg <= wait_next;
         fire_reg <= fire_next;
         stay_reg <= stay_next;
      end
   end

   // The pulse generator holds a request until the host releases the pin.
   ack_pulse_gen #(
      .PULSE_CYCLES(PULSE_CYCLES)
   ) u_pulse (
      .clk(clk),
      .rst_n(rst_n),
      .fire(fire_reg),
      .host_driving(host_driving),
      .pin_out(debug_serial_pin_out),
      .pin_oe(debug_serial_pin_oe),
      .busy()
   );

   assign ack_enabled = en_reg;
   assign ack_waiting = stay_reg;

endmodule : debug_port_ack_handshake

// ===== ack_props.sv
`timescale 1ns/1ps
module ack_props
   import dbg_ack_pkg::*;
#(
   parameter int PULSE_CYCLES = 16
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire cmd_s cmd_in,
   input wire core_evt_s core_evt,
   input wire logic host_driving,
   input wire logic debug_serial_pin_out,
   input wire logic debug_serial_pin_oe,
   input wire logic ack_enabled,
   input wire logic ack_waiting
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   logic [7:0] len_reg;
   logic [7:0] len_next;
   always_comb len_next = debug_serial_pin_oe ? len_reg + 8'h01 : 8'h00;
   always_ff @(posedge clk or negedge rst_n)
      if (!rst_n) len_reg <= 8'h00;
      else len_reg <= len_next;
   sequence sync_req;
      cmd_in.valid && cmd_in.cmd == CMD_SYNC;
   endsequence
   sequence run_req;
      cmd_in.valid && ack_enabled && cmd_in.cmd inside {CMD_HALT, CMD_RESUME, CMD_RESUME_UNTIL, CMD_STEP};
   endsequence
   // An acknowledge may slip only while the host holds the pin.
   property ack_after(go, evt);
      go && ack_enabled && !debug_serial_pin_oe ##1 (!cmd_in.valid && !evt)[*4]
         ##1 evt && !cmd_in.valid && !debug_serial_pin_oe |=> !ack_waiting
         ##1 ($rose(debug_serial_pin_oe) || $past(host_driving));
   endproperty
   en_on_a: assert property (cmd_in.valid && cmd_in.cmd == CMD_ACK_ENABLE |=> ack_enabled)
      else $error("enable command left handshake off");
   dis_off_a: assert property (cmd_in.valid && cmd_in.cmd == CMD_ACK_DISABLE |=> !ack_enabled)
      else $error("disable command left handshake on");
   en_ack_a: assert property (cmd_in.valid && cmd_in.cmd == CMD_ACK_ENABLE && !debug_serial_pin_oe
      |-> ##2 ($rose(debug_serial_pin_oe) || $past(host_driving)))
      else $error("enable command not acknowledged");
   off_quiet_a: assert property (cmd_in.valid && !ack_enabled && cmd_in.cmd != CMD_ACK_ENABLE
      |=> !ack_waiting) else $error("acknowledge pending while off");
   sync_cut_a: assert property (run_req ##1 sync_req |=> !ack_waiting)
      else $error("timing probe kept acknowledge");
   pulse_len_a: assert property ($fell(debug_serial_pin_oe) |-> len_reg == PULSE_CYCLES)
      else $error("acknowledge pulse length wrong");
   bus_ack_a: assert property (ack_after(cmd_in.cmd inside {CMD_READ, CMD_WRITE}, core_evt.bus_done))
      else $error("bus acknowledge wrong");
   enter_ack_a: assert property (ack_after(cmd_in.cmd inside {CMD_HALT, CMD_RESUME_UNTIL, CMD_STEP},
      core_evt.enter_halt_instruction))
      else $error("entry acknowledge wrong");
   exit_ack_a: assert property (ack_after(cmd_in.cmd == CMD_RESUME, core_evt.exit_halt_instruction))
      else $error("exit acknowledge wrong");
endmodule : ack_props
bind debug_port_ack_handshake ack_props #(.PULSE_CYCLES(PULSE_CYCLES)) u_ack_props (.clk, .rst_n,
   .cmd_in, .core_evt, .host_driving, .debug_serial_pin_out, .debug_serial_pin_oe, .ack_enabled,
   .ack_waiting);

// ===== dbg_host_model.sv
`timescale 1ns/1ps
module dbg_host_model
(
   input wire logic clk,
   input wire logic talk,
   input wire logic pin_oe,
   input wire logic pin_out,
   output logic host_driving,
   output logic [7:0] acks
);
   // The pin has a pull-up, so it reads high once the target lets go.
   wire logic pin_level = pin_oe ? pin_out : 1'b1;
   logic last_level = 1'b1;
   initial acks = 8'h00;
   initial host_driving = 1'b0;
   always @(posedge clk)
   begin
      host_driving <= talk;
      last_level <= pin_level;
      if (last_level && !pin_level) acks <= acks + 8'h01;
   end
endmodule : dbg_host_model

// ===== tb_debug_port_ack_handshake.sv
`timescale 1ns/1ps
module tb_debug_port_ack_handshake;
   import dbg_ack_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic talk = 1'b0;
   cmd_s cmd_in = '0;
   core_evt_s core_evt = '0;
   logic host_driving, debug_serial_pin_out, debug_serial_pin_oe, ack_enabled, ack_waiting;
   logic [7:0] acks;
   int err_total = 0;
   int n_tests = 0;
   debug_port_ack_handshake #(.PULSE_CYCLES(4)) u_debug_port_ack_handshake (.clk, .rst_n,
      .cmd_in, .core_evt, .host_driving, .debug_serial_pin_out, .debug_serial_pin_oe,
      .ack_enabled, .ack_waiting);
   dbg_host_model u_dbg_host_model (.clk, .talk, .pin_oe(debug_serial_pin_oe),
      .pin_out(debug_serial_pin_out), .host_driving, .acks);
   initial forever #12.5 clk = ~clk;
   task conclude;
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : conclude
   task chk(string what, logic [7:0] exp, logic [7:0] got);
      n_tests++;
      if (got !== exp)
      begin
         err_total++;
         $display("unexpected %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task send(cmd_e c);
      @(posedge clk) cmd_in <= '{1'b1, c};
      @(posedge clk) cmd_in <= '{1'b0, CMD_NONE};
   endtask : send
   task send2(cmd_e a, cmd_e b);
      @(posedge clk) cmd_in <= '{1'b1, a};
      @(posedge clk) cmd_in <= '{1'b1, b};
      @(posedge clk) cmd_in <= '{1'b0, CMD_NONE};
   endtask : send2
   task pulse(core_evt_s e);
      @(posedge clk) core_evt <= e;
      @(posedge clk) core_evt <= '0;
      repeat (10) @(posedge clk);
   endtask : pulse
   task automatic t_kinds;
      cmd_e cl [7] = '{CMD_READ, CMD_WRITE, CMD_CPU, CMD_HALT, CMD_RESUME, CMD_RESUME_UNTIL, CMD_STEP};
      core_evt_s el [7] = '{4'h8, 4'h8, 4'h4, 4'h2, 4'h1, 4'h2, 4'h2};
      for (int i = 0; i < 7; i++)
      begin
         send(cl[i]);
         repeat (3) @(posedge clk);
         chk("early", 8'(i + 1), acks);
         pulse(el[i]);
         chk("kind", 8'(i + 2), acks);
      end
   endtask : t_kinds
   initial
   begin
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      chk("reset_flag", 8'h00, {7'h00, ack_enabled});
      send(CMD_READ);
      pulse(4'h8);
      chk("off", 8'h00, acks);
      send(CMD_ACK_ENABLE);
      pulse(4'h0);
      chk("probe", 8'h01, acks);
      t_kinds();
      send2(CMD_HALT, CMD_SYNC);
      pulse(4'h2);
      chk("sync", 8'h08, acks);
      @(posedge clk) talk <= 1'b1;
      send(CMD_READ);
      pulse(4'h8);
      chk("held", 8'h08, acks);
      @(posedge clk) talk <= 1'b0;
      pulse(4'h0);
      chk("late", 8'h09, acks);
      send(CMD_ACK_DISABLE);
      send(CMD_WRITE);
      pulse(4'h8);
      chk("disabled_flag", 8'h00, {7'h00, ack_enabled});
      chk("disabled", 8'h09, acks);
      conclude();
   end
   initial
   begin
      repeat (2000) @(posedge clk);
      err_total++;
      conclude();
   end
endmodule : tb_debug_port_ack_handshake
